// ### ddr_cmd_map.vh
`ifndef DDR_CMD_MAP_VH
`define DDR_CMD_MAP_VH
// burst-mode field encodings (low two bits)
`define BURST_MODE_FIXED8   2'b00
`define BURST_MODE_OTF      2'b01
`define BURST_MODE_RESET    2'b01
// beat counts
`define BEATS_FULL          4'h8
`define BEATS_CHOP          4'h4
`define CCD_CYCLES          4'h4
// address field positions
`define ADDR_BURST_BIT      12
`define ADDR_AP_BIT         10
// refresh timing, ns, and derived core cycles at 10 ns
`define CLK_PERIOD_NS       10
`define RFC_TIME_NS         110
// RFC_TIME_NS rounded up to whole core cycles, sized for the 8-bit counter
`define RFC_CYCLES          8'h0b
`define RFC_RESET           8'h00
`define REF_ROW_RESET       14'h0000
// latency defaults
`define CAS_LAT_RESET       4'h5
`define ADD_LAT_RESET       4'h0
`endif

// ### beat_buffer.v
`timescale 1ns/100ps
`default_nettype none
// two-entry skid buffer for read beats
module beat_buffer (
   input  wire        core_clk_in,
   input  wire        rst_n_in,
   input  wire        in_valid_in,
   output wire        in_ready_out,
   input  wire [7:0]  in_data_in,
   output wire        out_valid_out,
   input  wire        out_ready_in,
   output wire [7:0]  out_data_out
);
   reg [7:0] mem_reg [0:1];
   reg       wr_ptr_reg;
   reg       rd_ptr_reg;
   reg [1:0] count_reg;
   wire      push;
   wire      pop;

   assign in_ready_out  = (count_reg != 2'h2);
   assign out_valid_out = (count_reg != 2'h0);
   assign out_data_out  = mem_reg[rd_ptr_reg];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   always @(posedge core_clk_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end

   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule
`default_nettype wire

// ### ddr_burst_refresh.v
`timescale 1ns/100ps
`default_nettype none
`include "ddr_cmd_map.vh"
module ddr_burst_refresh (
   input  wire        core_clk_in,
   input  wire        rst_n_in,
   input  wire        link_clk_in,
   input  wire        cs_n_in,
   input  wire        ras_n_in,
   input  wire        cas_n_in,
   input  wire        we_n_in,
   input  wire [13:0] addr_in,
   input  wire [1:0]  burst_mode_in,
   input  wire [3:0]  cas_latency_in,
   input  wire [3:0]  additive_latency_in,
   input  wire [7:0]  wr_data_in,
   input  wire        wr_timing_fault_in,
   output wire        rd_valid_out,
   input  wire        rd_ready_in,
   output wire [7:0]  rd_data_out,
   output reg         wr_beat_out,
   output reg  [7:0]  wr_data_out,
   output reg  [9:0]  col_addr_out,
   output reg         wr_corrupt_out,
   output reg         burst_full_out,
   output reg         refresh_busy_out,
   output reg  [13:0] refresh_row_out,
   output reg         banks_idle_out
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers (link clock, commands, data)
   reg [29:0] s1_reg;
   reg [29:0] s2_reg;
   reg        lclk_d_reg;
   wire       lclk_s  = s2_reg[29];
   wire       lclk_rise = lclk_s & ~lclk_d_reg;
   wire       cs_n_s  = s2_reg[28];
   wire       ras_n_s = s2_reg[27];
   wire       cas_n_s = s2_reg[26];
   wire       we_n_s  = s2_reg[25];
   wire [13:0] addr_s = s2_reg[24:11];
   wire [7:0] wd_s    = s2_reg[10:3];
   wire       fault_s = s2_reg[2];
   wire [1:0] mode_s  = s2_reg[1:0];

   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_reg     <= 30'h0;
         s2_reg     <= 30'h0;
         lclk_d_reg <= 1'b0;
      end else begin
         s1_reg     <= {link_clk_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, addr_in,
                        wr_data_in, wr_timing_fault_in, burst_mode_in};
         s2_reg     <= s1_reg;
         lclk_d_reg <= lclk_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // command decode on link rising edge
   wire cmd_ok  = lclk_rise & ~cs_n_s;
   wire is_ref  = cmd_ok & ~ras_n_s & ~cas_n_s & we_n_s;
   wire is_rd   = cmd_ok & ras_n_s & ~cas_n_s & we_n_s;
   wire is_wr   = cmd_ok & ras_n_s & ~cas_n_s & ~we_n_s;

   wire full8 = (mode_s == `BURST_MODE_FIXED8) |
                ((mode_s == `BURST_MODE_OTF) & addr_s[`ADDR_BURST_BIT]);

   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_WRITE = 2'h2;
   localparam ST_REF  = 2'h3;

   reg [1:0] state_reg;
   reg [3:0] lat_reg;
   reg [3:0] beats_reg;
   reg [7:0] rfc_reg;
   reg [7:0] rd_word_reg;
   reg       rd_push_reg;
   wire      buf_ready;
   wire [3:0] read_lat = additive_latency_in + cas_latency_in;
   wire [3:0] beats = full8 ? `BEATS_FULL : `BEATS_CHOP;

   ////////////////////////////////////////////////////////////////////
   // burst and refresh sequencer; bursts counted in link edges, refresh in core cycles
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg        <= ST_IDLE;
         lat_reg          <= 4'h0;
         beats_reg        <= 4'h0;
         rfc_reg          <= `RFC_RESET;
         rd_word_reg      <= 8'h00;
         rd_push_reg      <= 1'b0;
         wr_beat_out      <= 1'b0;
         wr_data_out      <= 8'h00;
         col_addr_out     <= 10'h000;
         wr_corrupt_out   <= 1'b0;
         burst_full_out   <= 1'b0;
         refresh_busy_out <= 1'b0;
         refresh_row_out  <= `REF_ROW_RESET;
         banks_idle_out   <= 1'b1;
      end else begin
         wr_beat_out <= 1'b0;
         // hold push until the buffer accepts; stall never drops a beat
         if (rd_push_reg & buf_ready) begin
            rd_push_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               // column from low bits only; bit 12 only selects burst length in OTF mode
               // auto-precharge bit does not affect burst choice
               if (is_rd | is_wr) begin
                  col_addr_out   <= addr_s[9:0];
                  burst_full_out <= full8;
                  beats_reg      <= beats;
                  wr_corrupt_out <= 1'b0;
                  banks_idle_out <= 1'b0;
                  lat_reg        <= read_lat;
                  state_reg      <= is_rd ? ST_READ : ST_WRITE;
               end else if (is_ref) begin
                  refresh_busy_out <= 1'b1;
                  banks_idle_out   <= 1'b0;
                  rfc_reg          <= `RFC_CYCLES;
                  state_reg        <= ST_REF;
               end
            end
            ST_READ: begin
               if (lclk_rise) begin
                  if (lat_reg > 4'h1) begin
                     lat_reg <= lat_reg - 4'h1;
                  end else if (beats_reg != 4'h0 && !rd_push_reg) begin
                     rd_word_reg  <= {col_addr_out[3:0], beats_reg};
                     rd_push_reg  <= 1'b1;
                     col_addr_out <= col_addr_out + 10'h001;
                     beats_reg    <= beats_reg - 4'h1;
                  end else if (beats_reg == 4'h0) begin
                     banks_idle_out <= 1'b1;
                     state_reg      <= ST_IDLE;
                  end
               end
            end
            ST_WRITE: begin
               if (lclk_rise) begin
                  if (beats_reg != 4'h0) begin
                     wr_beat_out  <= 1'b1;
                     wr_data_out  <= wd_s;
                     col_addr_out <= col_addr_out + 10'h001;
                     beats_reg    <= beats_reg - 4'h1;
                     // fault flags only this burst's location
                     // sequencer continues normally after a fault
                     if (fault_s) begin
                        wr_corrupt_out <= 1'b1;
                     end
                  end else begin
                     banks_idle_out <= 1'b1;
                     state_reg      <= ST_IDLE;
                  end
               end
            end
            ST_REF: begin
               if (rfc_reg != 8'h00) begin
                  rfc_reg <= rfc_reg - 8'h01;
               end else begin
                  refresh_busy_out <= 1'b0;
                  banks_idle_out   <= 1'b1;
                  refresh_row_out  <= refresh_row_out + 14'h0001;
                  state_reg        <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   beat_buffer u_buf (
      .core_clk_in   (core_clk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (rd_push_reg),
      .in_ready_out  (buf_ready),
      .in_data_in    (rd_word_reg),
      .out_valid_out (rd_valid_out),
      .out_ready_in  (rd_ready_in),
      .out_data_out  (rd_data_out)
   );
endmodule
`default_nettype wire

// ### ddr_burst_refresh_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_burst_refresh_chk (
   input wire logic        core_clk_in,
   input wire logic        rst_n_in,
   input wire logic        rd_valid_out,
   input wire logic        rd_ready_in,
   input wire logic [7:0]  rd_data_out,
   input wire logic        wr_beat_out,
   input wire logic [9:0]  col_addr_out,
   input wire logic        burst_full_out,
   input wire logic        refresh_busy_out,
   input wire logic [13:0] refresh_row_out,
   input wire logic        banks_idle_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   refresh_len_a: assert property ($rose(refresh_busy_out) |->
      refresh_busy_out[*8] ##1 refresh_busy_out[*4] ##1 !refresh_busy_out)
      else $error("refresh busy length wrong");
   row_step_a: assert property ($fell(refresh_busy_out) |->
      refresh_row_out == $past(refresh_row_out) + 14'h0001)
      else $error("refresh row did not step by one");
   row_hold_a: assert property (!$fell(refresh_busy_out) |-> $stable(refresh_row_out))
      else $error("refresh row moved outside refresh end");
   idle_after_a: assert property ($fell(refresh_busy_out) |-> banks_idle_out)
      else $error("banks not idle after refresh");
   busy_idle_a: assert property (refresh_busy_out |-> !banks_idle_out)
      else $error("banks idle while refreshing");
   col_keep_a: assert property (refresh_busy_out |-> $stable(col_addr_out))
      else $error("column changed during refresh");
   beat_gap_a: assert property (wr_beat_out |=> !wr_beat_out[*8])
      else $error("write beats too close");
   beat_mode_a: assert property (wr_beat_out |-> $stable(burst_full_out) && !refresh_busy_out)
      else $error("burst length moved during write");
   rd_hold_a: assert property (rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_data_out))
      else $error("read word lost while stalled");
endmodule
`default_nettype wire

// ### ddr_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_ctrl_model (
   input  wire logic       core_clk_in,
   output var  logic       link_clk_out,
   output var  logic       cs_n_out,
   output var  logic       ras_n_out,
   output var  logic       cas_n_out,
   output var  logic       we_n_out,
   output var  logic [13:0] addr_out,
   output var  logic [7:0] wr_data_out,
   output var  logic       fault_out
);
   // no bank ever opened, idle gaps kept by caller
   initial begin
      link_clk_out = 1'b0;
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
      addr_out = 14'h0000;
      wr_data_out = 8'h00;
      fault_out = 1'b0;
   end
   // one command per call, clock only in frames
   task automatic send(input logic [3:0] c, input logic [13:0] a, input int n, input int bad);
      int i;
      begin
         @(posedge core_clk_in);
         {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= c;
         addr_out <= a;
         for (i = 0; i < n; i++) begin
            repeat (8) @(posedge core_clk_in);
            link_clk_out <= 1'b1;
            repeat (8) @(posedge core_clk_in);
            link_clk_out <= 1'b0;
            {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'hf;
            // released address alternates between inverted and original value each frame
            addr_out <= ~a ^ {14{i[0]}};
            wr_data_out <= 8'h10 + i[7:0];
            fault_out <= (i == bad);
         end
         repeat (8) @(posedge core_clk_in);
      end
   endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        rd_ready = 1'b0;
   logic [1:0]  mode = 2'b01;
   logic [3:0]  stall = 4'h0;
   logic [3:0]  exp_nib = 4'h0;
   int          failures = 0, check_count = 0, beats, rds, nib_bad, first_rd, cyc = 0;
   int          exp_row = 0;
   logic [9:0]  last_col = 10'h000;
   wire         link, cs_n, ras_n, cas_n, we_n, fault, rd_valid, wr_beat;
   wire         corrupt, full, busy, idle;
   wire [13:0]  addr, row;
   wire [7:0]   wdata, rd_data, wd_out;
   wire [9:0]   col;
   always #5 core_clk = ~core_clk;
   ddr_ctrl_model mdl (.core_clk_in(core_clk), .link_clk_out(link), .cs_n_out(cs_n),
      .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .addr_out(addr),
      .wr_data_out(wdata), .fault_out(fault));
   ddr_burst_refresh dut (.core_clk_in(core_clk), .rst_n_in(rst_n), .link_clk_in(link),
      .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .addr_in(addr),
      .burst_mode_in(mode), .cas_latency_in(4'h5), .additive_latency_in(4'h0),
      .wr_data_in(wdata), .wr_timing_fault_in(fault), .rd_valid_out(rd_valid),
      .rd_ready_in(rd_ready), .rd_data_out(rd_data), .wr_beat_out(wr_beat),
      .wr_data_out(wd_out), .col_addr_out(col), .wr_corrupt_out(corrupt),
      .burst_full_out(full), .refresh_busy_out(busy), .refresh_row_out(row),
      .banks_idle_out(idle));
   // receiver stalls half of every 16 cycles
   always @(posedge core_clk) begin
      stall <= stall + 4'h1;
      rd_ready <= ~stall[3];
      cyc++;
      if (wr_beat === 1'b1) beats++;
      if (rd_valid === 1'b1 && first_rd == 0) first_rd = cyc;
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
         rds++;
         if (rd_data[7:4] !== exp_nib) nib_bad++;
         exp_nib = exp_nib + 4'h1;
      end
   end
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task finish_test;
      if (failures == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task t_write(input logic [1:0] m, input logic [13:0] a, input int n, input int bad);
      @(posedge core_clk);
      mode <= m;
      beats = 0;
      mdl.send(4'b0100, a, n + 2, bad);
      last_col = a[9:0] + n[9:0];
      chk("wr_beats", n, beats);
      chk("burst_full", n == 8, full);
      chk("col_addr", last_col, col);
      chk("wr_data", 8'h10 + n[7:0] - 8'h01, wd_out);
      chk("wr_corrupt", bad < n, corrupt);
   endtask
   task t_read(input logic [13:0] a, input int n);
      int t0;
      @(posedge core_clk);
      mode <= 2'b01;
      exp_nib = a[3:0];
      rds = 0;
      nib_bad = 0;
      first_rd = 0;
      t0 = cyc;
      mdl.send(4'b0101, a, n + 7, 99);
      repeat (40) @(posedge core_clk);
      last_col = a[9:0] + n[9:0];
      chk("rd_beats", n, rds);
      chk("rd_column", 0, nib_bad);
      chk("rd_latency", 1, first_rd - t0 >= 88 && first_rd - t0 <= 97);
      chk("corrupt_clear", 0, corrupt);
   endtask
   task t_refresh(input logic [13:0] a);
      mdl.send(4'b0001, a, 1, 99);
      repeat (20) @(posedge core_clk);
      exp_row++;
      chk("refresh_row", exp_row, row);
      chk("banks_idle", 1, idle);
      chk("refresh_col", last_col, col);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("idle_reset", 1, idle);
      t_refresh(14'h3fff);
      t_write(2'b01, 14'h03ff, 4, 99);
      t_write(2'b01, 14'h1405, 8, 2);
      t_write(2'b00, 14'h0407, 8, 99);
      t_read(14'h100a, 8);
      t_read(14'h0005, 4);
      t_refresh(14'h2aaa);
      finish_test();
   end
   initial begin
      #100us;
      failures++;
      finish_test();
   end
endmodule
bind ddr_burst_refresh ddr_burst_refresh_chk chk (.core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in), .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
   .rd_data_out(rd_data_out), .wr_beat_out(wr_beat_out), .col_addr_out(col_addr_out),
   .burst_full_out(burst_full_out), .refresh_busy_out(refresh_busy_out),
   .refresh_row_out(refresh_row_out), .banks_idle_out(banks_idle_out));
`default_nettype wire
